// File: rtl/timer16_consts.svh
// register indices, field positions, reset values and counts of the timer slice
// assumes it is included by bare name from the timer rtl files
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define IDX_CTRL_A 10'h080
`define IDX_CTRL_B 10'h081
`define IDX_FORCE 10'h082
`define IDX_CNT_LO 10'h084
`define IDX_CNT_HI 10'h085
`define IDX_CAP_LO 10'h086
`define IDX_CAP_HI 10'h087
`define IDX_CMPA_LO 10'h088
`define IDX_CMPA_HI 10'h089
`define IDX_AUX 10'h090

// ==========================================================
// reset values and masks
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_DATA 32'h00000000
`define CTRL_B_MASK 8'hDF

// ==========================================================
// field positions
`define B_FILT_EN 7
`define B_EDGE_SEL 6
`define B_WGM3 4
`define B_WGM2 3
`define CS_HI 2
`define CS_LO 0
`define B_FORCE_A 7
`define B_FORCE_B 6
`define COMA_HI 7
`define COMA_LO 6
`define COMB_HI 5
`define COMB_LO 4
`define WGM_HI 1
`define WGM_LO 0
`define B_AUX_FLAG 0
`define B_AUX_SRC 1

// ==========================================================
// counter tops and prescaler tap masks
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define TOP_MAX 16'hFFFF
`define ONE_WORD 16'h0001
`define DIV8_M 10'h007
`define DIV64_M 10'h03F
`define DIV256_M 10'h0FF
`define DIV1024_M 10'h3FF
`define PRE_ONE 10'h001
`define FILT_LEN 4

`endif

// File: rtl/timer16_pkg.sv
// types shared by the timer slice
// assumes nothing beyond a SystemVerilog compiler
package timer16_pkg;

  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    cs_stop = 3'b000,
    cs_div1 = 3'b001,
    cs_div8 = 3'b010,
    cs_div64 = 3'b011,
    cs_div256 = 3'b100,
    cs_div1024 = 3'b101,
    cs_ext_fall = 3'b110,
    cs_ext_rise = 3'b111
  } clk_sel_type;

  typedef enum logic [3:0] {
    wm_normal = 4'b0000, wm_pc8 = 4'b0001, wm_pc9 = 4'b0010, wm_pc10 = 4'b0011,
    wm_ctc_a = 4'b0100, wm_fast8 = 4'b0101, wm_fast9 = 4'b0110, wm_fast10 = 4'b0111,
    wm_pfc_i = 4'b1000, wm_pfc_a = 4'b1001, wm_pc_i = 4'b1010, wm_pc_a = 4'b1011,
    wm_ctc_i = 4'b1100, wm_rsvd = 4'b1101, wm_fast_i = 4'b1110, wm_fast_a = 4'b1111
  } wave_mode_type;

  typedef enum logic [1:0] {
    oa_none = 2'b00,
    oa_toggle = 2'b01,
    oa_clear = 2'b10,
    oa_set = 2'b11
  } out_act_type;

endpackage

// File: rtl/capture_filter.sv
// capture input noise filter: four equal samples needed to change the level
// assumes src is already synchronous to pclk
`include "timer16_consts.svh"

module capture_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src,
  input wire logic filt_en,
  output logic level
);

  // ==========================================================
  // sample history and level
  logic [`FILT_LEN-1:0] hist_q;
  logic level_q;
  logic all_hi;
  logic all_lo;
  logic filt_next;

  assign all_hi = &hist_q;
  assign all_lo = ~|hist_q;
  assign filt_next = all_hi ? 1'b1 : (all_lo ? 1'b0 : level_q);
  assign level = level_q;

  // unfiltered path shares the level flop so both modes differ by exactly the history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= '0;
      level_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[`FILT_LEN-2:0], src};
      level_q <= filt_en ? filt_next : src;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_filt_four_equal: assert property (
    $past(filt_en) && (level_q != $past(level_q)) |-> $past(hist_q) == {`FILT_LEN{level_q}}
  ) else $error("filtered level changed without four equal samples");

  a_filt_no_extra: assert property (
    filt_en && (hist_q == {`FILT_LEN{!level_q}}) |=> level_q == $past(hist_q[0])
  ) else $error("filtered level late after four equal samples");

endmodule

// File: rtl/count_tick_gen.sv
// counting clock enable: prescaler taps or external pin edges
// assumes ext_pin is synchronous to pclk
`include "timer16_consts.svh"

module count_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire timer16_pkg::clk_sel_type clk_sel,
  input wire logic ext_pin,
  output logic tick
);

  // ==========================================================
  // prescaler and edge detect
  logic [9:0] pre_q;
  logic ext_prev_q;
  logic [9:0] mask;
  logic div_hit;
  logic ext_rise;
  logic ext_fall;

  // free running, so a new tap may fire early on its first period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      ext_prev_q <= 1'b0;
    end else begin
      pre_q <= pre_q + `PRE_ONE;
      ext_prev_q <= ext_pin;
    end
  end

  assign mask = (clk_sel == timer16_pkg::cs_div8) ? `DIV8_M :
                (clk_sel == timer16_pkg::cs_div64) ? `DIV64_M :
                (clk_sel == timer16_pkg::cs_div256) ? `DIV256_M : `DIV1024_M;
  assign div_hit = (pre_q & mask) == mask;
  assign ext_rise = ext_pin & ~ext_prev_q;
  assign ext_fall = ~ext_pin & ext_prev_q;
  assign tick = (clk_sel == timer16_pkg::cs_stop) ? 1'b0 :
                (clk_sel == timer16_pkg::cs_div1) ? 1'b1 :
                (clk_sel == timer16_pkg::cs_ext_fall) ? ext_fall :
                (clk_sel == timer16_pkg::cs_ext_rise) ? ext_rise : div_hit;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_tick_stopped: assert property (
    clk_sel == timer16_pkg::cs_stop |-> !tick
  ) else $error("tick while clock source stopped");

  a_div8_spacing: assert property (
    (clk_sel == timer16_pkg::cs_div8) && tick |=> (!tick || clk_sel != timer16_pkg::cs_div8)[*7]
  ) else $error("divide by eight tick too soon");

  a_ext_rise_edge: assert property (
    (clk_sel == timer16_pkg::cs_ext_rise) && tick |-> ext_pin && !$past(ext_pin)
  ) else $error("rising external tick without rising edge");

endmodule

// File: rtl/timer16_capture_ctrl_regs.sv
// control, capture and byte-paired register slice of a 16-bit timer
// assumes an APB master on pclk and capture, count pins synchronous to pclk
//
// The implementer's own choice: the APB register port.
`include "timer16_consts.svh"

// What this block does
// - filter changes after four equal samples
// - filter delays capture by exactly four cycles
// - edge select: zero falling, one rising
// - capture copies count and sets flag
// - capture pin ignored when capture is top
// - clock select stop or divide 1..1024
// - codes six, seven count external pin edges
// - force strobes ignored in PWM modes
// - force applies compare action from output mode
// - force sets no flag, never clears counter
// - force bits are strobes, read zero
// - high byte sits at base plus one
// - shared high byte latch makes access atomic
// - count write suppresses next compare match
// - capture source pin or comparator output
// - upper mode bits in control register B
// - flag cleared by vector or one written
module timer16_capture_ctrl_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic ext_count_pin,
  input wire logic capture_vector_ack,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic capture_flag,
  output logic cmp_a_match
);

  // ==========================================================
  // functions
  function automatic logic hit(input logic [9:0] idx, input logic [9:0] target);
    hit = (idx == target);
  endfunction

  function automatic logic wave_next(input timer16_pkg::out_act_type act, input logic cur);
    case (act)
      timer16_pkg::oa_toggle: wave_next = ~cur;
      timer16_pkg::oa_clear: wave_next = 1'b0;
      timer16_pkg::oa_set: wave_next = 1'b1;
      default: wave_next = cur;
    endcase
  endfunction

  function automatic logic is_pwm(input timer16_pkg::wave_mode_type m);
    case (m)
      timer16_pkg::wm_normal: is_pwm = 1'b0;
      timer16_pkg::wm_ctc_a: is_pwm = 1'b0;
      timer16_pkg::wm_ctc_i: is_pwm = 1'b0;
      timer16_pkg::wm_rsvd: is_pwm = 1'b0;
      default: is_pwm = 1'b1;
    endcase
  endfunction

  function automatic logic top_is_capture(input timer16_pkg::wave_mode_type m);
    case (m)
      timer16_pkg::wm_pfc_i: top_is_capture = 1'b1;
      timer16_pkg::wm_pc_i: top_is_capture = 1'b1;
      timer16_pkg::wm_ctc_i: top_is_capture = 1'b1;
      timer16_pkg::wm_fast_i: top_is_capture = 1'b1;
      default: top_is_capture = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // state
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] cap_q;
  logic [15:0] cap_d;
  logic [15:0] cmpa_q;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] snap_q;
  logic flag_q;
  logic flag_d;
  logic src_sel_q;
  logic suppress_q;
  logic suppress_d;
  logic wave_a_q;
  logic wave_a_d;
  logic wave_b_q;
  logic wave_b_d;
  logic match_q;
  logic cap_prev_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ==========================================================
  // bus decode
  logic setup;
  logic acc;
  logic wr;
  logic rd_acc;
  logic [9:0] widx;
  logic [7:0] wbyte;
  logic sel_ctrl_a;
  logic sel_ctrl_b;
  logic sel_force;
  logic sel_cnt_lo;
  logic sel_cnt_hi;
  logic sel_cap_lo;
  logic sel_cap_hi;
  logic sel_cmpa_lo;
  logic sel_cmpa_hi;
  logic sel_aux;
  logic sel_lo;
  logic sel_hi;
  logic mapped;
  logic [31:0] rd_word;
  logic [7:0] snap_hi;
  logic [15:0] wr_word;

  assign setup = psel & ~penable;
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign widx = paddr[11:2];
  assign wbyte = pwdata[7:0];
  assign sel_ctrl_a = hit(widx, `IDX_CTRL_A);
  assign sel_ctrl_b = hit(widx, `IDX_CTRL_B);
  assign sel_force = hit(widx, `IDX_FORCE);
  assign sel_cnt_lo = hit(widx, `IDX_CNT_LO);
  assign sel_cnt_hi = hit(widx, `IDX_CNT_HI);
  assign sel_cap_lo = hit(widx, `IDX_CAP_LO);
  assign sel_cap_hi = hit(widx, `IDX_CAP_HI);
  assign sel_cmpa_lo = hit(widx, `IDX_CMPA_LO);
  assign sel_cmpa_hi = hit(widx, `IDX_CMPA_HI);
  assign sel_aux = hit(widx, `IDX_AUX);
  assign sel_lo = sel_cnt_lo | sel_cap_lo | sel_cmpa_lo;
  assign sel_hi = sel_cnt_hi | sel_cap_hi | sel_cmpa_hi;
  assign mapped = sel_ctrl_a | sel_ctrl_b | sel_force | sel_lo | sel_hi | sel_aux;

  // high bytes read back the latch, not the live register
  assign rd_word = sel_ctrl_a ? {24'h000000, ctrl_a_q} :
                   sel_ctrl_b ? {24'h000000, ctrl_b_q} :
                   sel_cnt_lo ? {24'h000000, count_q[7:0]} :
                   sel_cap_lo ? {24'h000000, cap_q[7:0]} :
                   sel_cmpa_lo ? {24'h000000, cmpa_q[7:0]} :
                   sel_hi ? {24'h000000, latch_q} :
                   sel_aux ? {30'h00000000, src_sel_q, flag_q} : `RST_DATA;

  // high byte is snapped with the low byte so both come from one instant
  assign snap_hi = sel_cnt_lo ? count_q[15:8] :
                   sel_cap_lo ? cap_q[15:8] :
                   sel_cmpa_lo ? cmpa_q[15:8] : latch_q;

  assign latch_d = (wr & sel_hi) ? wbyte :
                   (rd_acc & sel_lo) ? snap_q : latch_q;
  assign wr_word = {latch_q, wbyte};

  // ==========================================================
  // mode decode
  timer16_pkg::wave_mode_type wmode;
  timer16_pkg::clk_sel_type csel;
  timer16_pkg::out_act_type act_a;
  timer16_pkg::out_act_type act_b;
  logic pwm;
  logic top_cap;
  logic [15:0] top;
  logic tick;

  assign wmode = timer16_pkg::wave_mode_type'({ctrl_b_q[`B_WGM3], ctrl_b_q[`B_WGM2],
                                               ctrl_a_q[`WGM_HI:`WGM_LO]});
  assign csel = timer16_pkg::clk_sel_type'(ctrl_b_q[`CS_HI:`CS_LO]);
  assign act_a = timer16_pkg::out_act_type'(ctrl_a_q[`COMA_HI:`COMA_LO]);
  assign act_b = timer16_pkg::out_act_type'(ctrl_a_q[`COMB_HI:`COMB_LO]);
  assign pwm = is_pwm(wmode);
  assign top_cap = top_is_capture(wmode);

  // single-slope counting only; dual-slope direction lives in the waveform unit
  assign top = (wmode == timer16_pkg::wm_pc8 || wmode == timer16_pkg::wm_fast8) ? `TOP_8 :
               (wmode == timer16_pkg::wm_pc9 || wmode == timer16_pkg::wm_fast9) ? `TOP_9 :
               (wmode == timer16_pkg::wm_pc10 || wmode == timer16_pkg::wm_fast10) ? `TOP_10 :
               top_cap ? cap_q :
               (wmode == timer16_pkg::wm_normal || wmode == timer16_pkg::wm_rsvd) ? `TOP_MAX :
               cmpa_q;

  count_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clk_sel(csel),
    .ext_pin(ext_count_pin),
    .tick(tick)
  );

  // ==========================================================
  // counter and compare A
  logic cnt_wr;
  logic match_a;
  logic force_a;
  logic force_b;

  assign cnt_wr = wr & sel_cnt_lo;
  assign match_a = tick & ~suppress_q & (count_q == cmpa_q);
  assign count_d = cnt_wr ? wr_word :
                   tick ? ((count_q == top) ? `RST_WORD : count_q + `ONE_WORD) : count_q;
  assign suppress_d = cnt_wr ? 1'b1 : (tick ? 1'b0 : suppress_q);

  // force only touches the wave outputs: no match pulse, no counter clear
  assign force_a = wr & sel_force & wbyte[`B_FORCE_A] & ~pwm;
  assign force_b = wr & sel_force & wbyte[`B_FORCE_B] & ~pwm;
  assign wave_a_d = force_a ? wave_next(act_a, wave_a_q) :
                    (match_a & ~pwm) ? wave_next(act_a, wave_a_q) : wave_a_q;
  assign wave_b_d = force_b ? wave_next(act_b, wave_b_q) : wave_b_q;

  // ==========================================================
  // capture path
  logic cap_src;
  logic cap_level;
  logic cap_edge;
  logic cap_evt;
  logic flag_clr;

  assign cap_src = src_sel_q ? comparator_out : capture_pin;

  capture_filter u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .src(cap_src),
    .filt_en(ctrl_b_q[`B_FILT_EN]),
    .level(cap_level)
  );

  assign cap_edge = ctrl_b_q[`B_EDGE_SEL] ? (cap_level & ~cap_prev_q) :
                    (~cap_level & cap_prev_q);
  assign cap_evt = cap_edge & ~top_cap;
  // a capture beats a software write landing in the same cycle
  assign cap_d = cap_evt ? count_q :
                 (wr & sel_cap_lo) ? wr_word : cap_q;
  assign flag_clr = capture_vector_ack | (wr & sel_aux & wbyte[`B_AUX_FLAG]);
  assign flag_d = cap_evt | (flag_q & ~flag_clr);

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= `RST_BYTE;
      ctrl_b_q <= `RST_BYTE;
      cmpa_q <= `RST_WORD;
      src_sel_q <= 1'b0;
    end else if (wr) begin
      if (sel_ctrl_a) begin
        ctrl_a_q <= wbyte;
      end else if (sel_ctrl_b) begin
        ctrl_b_q <= wbyte & `CTRL_B_MASK;
      end else if (sel_cmpa_lo) begin
        cmpa_q <= wr_word;
      end else if (sel_aux) begin
        src_sel_q <= wbyte[`B_AUX_SRC];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= `RST_WORD;
      cap_q <= `RST_WORD;
      latch_q <= `RST_BYTE;
      flag_q <= 1'b0;
      suppress_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      count_q <= count_d;
      cap_q <= cap_d;
      latch_q <= latch_d;
      flag_q <= flag_d;
      suppress_q <= suppress_d;
      cap_prev_q <= cap_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
      match_q <= match_a;
    end
  end

  // read data is prepared in the setup cycle, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `RST_DATA;
      snap_q <= `RST_BYTE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= pwrite ? `RST_DATA : rd_word;
        snap_q <= snap_hi;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wave_out_a = wave_a_q;
  assign wave_out_b = wave_b_q;
  assign capture_flag = flag_q;
  assign cmp_a_match = match_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cap_copy_count: assert property (
    cap_evt |=> (cap_q == $past(count_q)) && flag_q
  ) else $error("capture did not copy count or set flag");

  a_cap_edge_dir: assert property (
    cap_evt |-> (cap_level == ctrl_b_q[`B_EDGE_SEL]) && (cap_prev_q != cap_level)
  ) else $error("capture on wrong edge");

  a_cap_top_off: assert property (
    top_cap |=> cap_q == $past(cap_q) || $past(wr && sel_cap_lo)
  ) else $error("capture value moved while used as top");

  a_force_pwm_off: assert property (
    pwm && wr && sel_force |=> $stable(wave_a_q) && $stable(wave_b_q)
  ) else $error("force took effect in pwm mode");

  a_force_toggle_a: assert property (
    !pwm && wr && sel_force && wbyte[`B_FORCE_A] && (act_a == timer16_pkg::oa_toggle)
    |=> wave_a_q != $past(wave_a_q)
  ) else $error("forced toggle not applied to channel a");

  a_force_no_match: assert property (
    wr && sel_force && !match_a && !cap_evt |=> !match_q && (flag_q == $past(flag_q) || !flag_q)
  ) else $error("force produced a match or flag");

  a_force_reads_zero: assert property (
    setup && !pwrite && sel_force |=> prdata_q == `RST_DATA
  ) else $error("force register read not zero");

  a_pair_commit: assert property (
    cnt_wr |=> count_q == {$past(latch_q), $past(wbyte)}
  ) else $error("count write did not commit latched high byte");

  a_hi_latch_only: assert property (
    wr && sel_cnt_hi && !tick |=> (latch_q == $past(wbyte)) && (count_q == $past(count_q))
  ) else $error("high byte write did not go to latch alone");

  a_suppress_next: assert property (
    cnt_wr ##1 tick |=> !match_q
  ) else $error("match not suppressed after count write");

  a_flag_clear: assert property (
    flag_q && capture_vector_ack && !cap_evt |=> !flag_q
  ) else $error("capture flag not cleared by vector");

endmodule

// File: testbench/pin_partner.sv
// far-side pin model: drives capture and external count pins
// assumes the bench sets the wanted levels; pins change just after a pclk edge
module pin_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cap_lvl,
  input wire logic ext_lvl,
  output logic capture_pin,
  output logic ext_count_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // pins
  // registered so every level lasts whole pclk cycles, like a synchronised pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_pin <= 1'b0;
      ext_count_pin <= 1'b0;
    end else begin
      capture_pin <= cap_lvl;
      ext_count_pin <= ext_lvl;
    end
  end
endmodule

// File: testbench/timer16_capture_ctrl_regs_tb.sv
// self-checking bench of the timer register slice
// assumes the slice answers APB one cycle after setup, as the hand-over says
`include "timer16_consts.svh"
module timer16_capture_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic comparator_out = 0, capture_vector_ack = 0, cap_lvl = 0, ext_lvl = 0, serr, seen;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rs = 32'd91295;
  logic [7:0] rdat;
  logic [15:0] v, k;
  logic [9:0] idxs [10];
  wire [31:0] prdata;
  wire pready, pslverr, capture_pin, ext_count_pin, wave_out_a, wave_out_b;
  wire capture_flag, cmp_a_match;
  int fail_count = 0, checks = 0, cyc = 0, d, d0, n, e;
  // ==========================================================
  // instances
  timer16_capture_ctrl_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .comparator_out(comparator_out), .ext_count_pin(ext_count_pin),
    .capture_vector_ack(capture_vector_ack), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .capture_flag(capture_flag), .cmp_a_match(cmp_a_match));
  pin_partner far (.pclk(pclk), .presetn(presetn), .cap_lvl(cap_lvl), .ext_lvl(ext_lvl),
    .capture_pin(capture_pin), .ext_count_pin(ext_count_pin));
  initial begin
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int exp_ticks(input int code, input int cycles);
    int dv [6] = '{0, 1, 8, 64, 256, 1024};
    return (code == 0) ? 0 : cycles / dv[code];
  endfunction
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one APB transfer; the wait for pready is bounded only by the timeout
  task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, dt};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata[7:0];
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr16(input logic [9:0] i, input logic [15:0] x);
    xfer(1'b1, i + 10'h001, x[15:8]);
    xfer(1'b1, i, x[7:0]);
  endtask
  task automatic rd16(input logic [9:0] i, output logic [15:0] x);
    xfer(1'b0, i, 8'h00);
    x[7:0] = rdat;
    xfer(1'b0, i + 10'h001, 8'h00);
    x[15:8] = rdat;
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cmp_a_match === 1'b1) seen <= 1'b1;
    if (cyc == 50000) begin
      fail_count++;
      $display("[ERR] run length expected under 50000 seen %0d", cyc);
      test_done();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    idxs = '{`IDX_CTRL_A, `IDX_CTRL_B, `IDX_FORCE, `IDX_CNT_LO, `IDX_CNT_HI,
      `IDX_CAP_LO, `IDX_CAP_HI, `IDX_CMPA_LO, `IDX_CMPA_HI, `IDX_AUX};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idxs[j]) begin
      xfer(1'b0, idxs[j], 8'h00);
      chk("reset value", 16'h0000, {8'h00, rdat});
    end
    xfer(1'b0, 10'h0A0, 8'h00);
    chk("unmapped error", 16'h0001, {15'h0000, serr});
    xfer(1'b1, `IDX_CTRL_B, 8'hFF);
    xfer(1'b0, `IDX_CTRL_B, 8'h00);
    chk("ctrl_b readback", 16'h00DF, {8'h00, rdat});
    xfer(1'b1, `IDX_CTRL_B, 8'h00);
    // random word pairs through the shared high byte latch
    for (int j = 0; j < 4; j++) begin
      rs = xs(rs);
      wr16(`IDX_CMPA_LO, rs[15:0]);
      wr16(`IDX_CNT_LO, rs[31:16]);
      rd16(`IDX_CMPA_LO, v);
      chk("cmp a word", rs[15:0], v);
      rd16(`IDX_CNT_LO, v);
      chk("count word", rs[31:16], v);
    end
    // prescaler taps; a loose tolerance covers the write latency and the short first period
    for (int c = 1; c < 6; c++) begin
      wr16(`IDX_CNT_LO, 16'h0000);
      xfer(1'b1, `IDX_CTRL_B, c[7:0]);
      repeat (4000) @(posedge pclk);
      xfer(1'b1, `IDX_CTRL_B, 8'h00);
      rd16(`IDX_CNT_LO, v);
      e = exp_ticks(c, 4003);
      checks++;
      if ($isunknown(v) || int'(v) > e + 2 || int'(v) + 2 < e) begin
        fail_count++;
        $display("[ERR] prescaled count expected %0d seen %0d", e, v);
      end
    end
    // external pin: ends high, so rising edges outnumber falling by one
    for (int c = 6; c < 8; c++) begin
      wr16(`IDX_CNT_LO, 16'h0000);
      xfer(1'b1, `IDX_CTRL_B, c[7:0]);
      rs = xs(rs);
      n = rs[2:0] + 1;
      for (int j = 0; j <= n; j++) begin
        ext_lvl <= 1'b1;
        repeat (3) @(posedge pclk);
        if (j < n) ext_lvl <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      xfer(1'b1, `IDX_CTRL_B, 8'h00);
      ext_lvl <= 1'b0;
      rd16(`IDX_CNT_LO, v);
      chk("external count", (c == 7) ? n + 1 : n, v);
    end
    // capture latency without and with the filter, glitch first when filtered
    for (int f = 0; f < 2; f++) begin
      rs = xs(rs);
      k = rs[15:0];
      wr16(`IDX_CNT_LO, k);
      xfer(1'b1, `IDX_AUX, 8'h01);
      xfer(1'b1, `IDX_CTRL_B, {f[0], 7'h40});
      if (f == 1) begin
        cap_lvl <= 1'b0;
        repeat (10) @(posedge pclk);
        cap_lvl <= 1'b1;
        repeat (3) @(posedge pclk);
        cap_lvl <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("glitch flag", 16'h0000, {15'h0000, capture_flag});
      end
      cap_lvl <= 1'b1;
      d = 0;
      while (d < 20 && capture_flag !== 1'b1) begin
        @(posedge pclk);
        d++;
      end
      if (f == 0) d0 = d;
      rd16(`IDX_CAP_LO, v);
      chk("captured count", k, v);
    end
    chk("filter delay", 16'd4, d - d0);
    xfer(1'b1, `IDX_AUX, 8'h01);
    xfer(1'b1, `IDX_CTRL_B, 8'h00);
    cap_lvl <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("falling edge flag", 16'h0001, {15'h0000, capture_flag});
    capture_vector_ack <= 1'b1;
    @(posedge pclk);
    capture_vector_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("flag after vector", 16'h0000, {15'h0000, capture_flag});
    // capture register as top: pin edges must be ignored
    xfer(1'b1, `IDX_CTRL_B, 8'h18);
    cap_lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    cap_lvl <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("flag when capture is top", 16'h0000, {15'h0000, capture_flag});
    xfer(1'b1, `IDX_CTRL_B, 8'h00);
    xfer(1'b1, `IDX_AUX, 8'h02);
    comparator_out <= 1'b1;
    repeat (4) @(posedge pclk);
    comparator_out <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("comparator capture", 16'h0001, {15'h0000, capture_flag});
    xfer(1'b1, `IDX_AUX, 8'h01);
    // forced compares in compare-A clear mode, counter stopped at the compare value
    wr16(`IDX_CNT_LO, 16'h1234);
    wr16(`IDX_CMPA_LO, 16'h1234);
    xfer(1'b1, `IDX_CTRL_B, 8'h08);
    xfer(1'b1, `IDX_CTRL_A, 8'h70);
    seen <= 1'b0;
    xfer(1'b1, `IDX_FORCE, 8'hC0);
    repeat (3) @(posedge pclk);
    chk("forced outputs", 16'h0003, {14'h0000, wave_out_a, wave_out_b});
    chk("force side effects", 16'h0000, {14'h0000, seen, capture_flag});
    rd16(`IDX_CNT_LO, v);
    chk("count after force", 16'h1234, v);
    xfer(1'b0, `IDX_FORCE, 8'h00);
    chk("force readback", 16'h0000, {8'h00, rdat});
    xfer(1'b1, `IDX_CTRL_A, 8'h71);
    xfer(1'b1, `IDX_FORCE, 8'h80);
    repeat (3) @(posedge pclk);
    chk("force in pwm", 16'h0001, {15'h0000, wave_out_a});
    xfer(1'b1, `IDX_CTRL_A, 8'h70);
    xfer(1'b1, `IDX_FORCE, 8'h80);
    repeat (3) @(posedge pclk);
    chk("force toggle", 16'h0000, {15'h0000, wave_out_a});
    // count write blocks the next match; an earlier start reaches it
    xfer(1'b1, `IDX_CTRL_A, 8'h00);
    wr16(`IDX_CMPA_LO, 16'h0010);
    xfer(1'b1, `IDX_CTRL_B, 8'h01);
    seen <= 1'b0;
    wr16(`IDX_CNT_LO, 16'h0010);
    repeat (4) @(posedge pclk);
    chk("match after count write", 16'h0000, {15'h0000, seen});
    wr16(`IDX_CNT_LO, 16'h000D);
    repeat (8) @(posedge pclk);
    chk("later match", 16'h0001, {15'h0000, seen});
    test_done();
  end
endmodule
